// ---- rtl/ecdma_params.svh ----
// Register indices, field positions, reset values and masks of the controller.
`ifndef ECDMA_PARAMS_SVH
`define ECDMA_PARAMS_SVH
// ----------------------------------------------------------------------
// Register map: channel n at n*8 + index, globals at 0x40 and up.
// ----------------------------------------------------------------------
`define ECD_R_CTRL      3'h0
`define ECD_R_REQ       3'h1
`define ECD_R_PRIM      3'h2
`define ECD_R_SEC       3'h3
`define ECD_R_PERADDR   3'h4
`define ECD_R_COUNT     3'h5
`define ECD_G_LASTADDR  8'h40
`define ECD_G_COLL      8'h41
`define ECD_G_LASTCH    8'h42
// ----------------------------------------------------------------------
// Field positions and masks.
// ----------------------------------------------------------------------
`define ECD_B_EN        15
`define ECD_B_SIZE      14
`define ECD_B_DIR       13
`define ECD_B_HALF      12
`define ECD_B_NULL_WRITE_SELECT     11
`define ECD_B_FORCE     15
`define ECD_CTRL_MASK   16'hf833
`define ECD_REQ_MASK    16'h007f
`define ECD_COUNT_MASK  16'h03ff
`define ECD_LASTCH_RST  4'hf
`define ECD_INC_BYTE    16'h0001
`define ECD_INC_WORD    16'h0002
`endif

// ---- rtl/ecdma_pkg.sv ----
// Types shared by the controller.
package ecdma_pkg;
    // Engine states of one element move.
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_CAPT, ST_WRITE} ecdma_state_t;
    // Addressing select codes; code 3 is reserved.
    typedef enum logic [1:0] {
        AM_POSTINC = 2'h0,
        AM_NOINC   = 2'h1,
        AM_PERIND  = 2'h2,
        AM_RSVD    = 2'h3
    } ecdma_addressing_select_t;
endpackage : ecdma_pkg

// ---- rtl/ecdma_top.sv ----
// Eight-channel direct memory transfer controller with register port.
`timescale 1ns/10ps
`include "ecdma_params.svh"
// Operation
// - Every channel moves data one way only.
// - Fixed priority grants; losers stay pending.
// - Block up to 1024 elements, then interrupt.
// - Own bus on second memory port.
// - Control register holds enable, size, direction and mode bits.
// - Size bit selects byte or word.
// - Null write to peripheral on memory writes.
// - Half bit picks half or full interrupt.
// - Addressing: post-increment, fixed, peripheral indirect.
// - One-shot stops; repeating restarts block.
// - Ping-pong alternates primary and secondary start.
// - Start registers hold offsets in memory.
// - Start reads return latest used offset.
// - Peripheral address fixed, readable and writable.
// - Block ends after count plus one.
// - Count is elements regardless of size.
// - Last memory address register, reset zero.
// - Memory and peripheral collision flags per channel.
// - Last channel and ping-pong select status.
// - Force bit starts one manual transfer.
// - Seven-bit selector picks trigger source.
// - Hardware clears force after forced transfer.
// - Count is ten low bits.
module ecdma_top #(
    parameter int NCH = 8,
    parameter int CW  = 10
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Trigger sources, one-cycle pulses.
    input  wire logic [127:0] irq_src,
    // Memory second port.
    output logic      [15:0] mem_addr,
    output logic      [15:0] mem_wdata,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic             mem_byte,
    input  wire logic [15:0] mem_rdata,
    input  wire logic        mem_collide,
    // Peripheral bus.
    output logic      [15:0] per_addr,
    output logic      [15:0] per_wdata,
    output logic             per_rd,
    output logic             per_wr,
    output logic             per_byte,
    input  wire logic [15:0] per_rdata,
    input  wire logic [15:0] per_ind_addr,
    input  wire logic        per_collide,
    // Block interrupts, one-cycle pulses.
    output logic [NCH-1:0]   block_irq
);
    // ------------------------------------------------------------------
    // Channel storage.
    // ------------------------------------------------------------------
    logic [15:0]   ctrl     [NCH];  // Control word per channel.
    logic [15:0]   reqsel   [NCH];  // Force bit and source select.
    logic [15:0]   prim_off [NCH];  // Primary start offset.
    logic [15:0]   sec_off  [NCH];  // Secondary start offset.
    logic [15:0]   peraddr  [NCH];  // Peripheral data register address.
    logic [CW-1:0] count    [NCH];  // Elements minus one.
    logic [15:0]   cur_off  [NCH];  // Next memory offset.
    logic [15:0]   used_off [NCH];  // Latest offset used.
    logic [CW-1:0] xcount   [NCH];  // Elements done in this block.
    logic [NCH-1:0] pp;             // Ping-pong select, 1 = secondary.
    logic [NCH-1:0] pend;           // Request waiting for service.
    logic [NCH-1:0] mcol;           // Memory write collision flags.
    logic [NCH-1:0] pcol;           // Peripheral write collision flags.
    // Engine state.
    ecdma_pkg::ecdma_state_t st;    // Element move state.
    logic [2:0]    act;             // Channel being serviced.
    logic [15:0]   last_mem_addr;   // Shared last memory address.
    logic [3:0]    lastch;          // Most recently active channel.
    logic [NCH-1:0] ready;          // Enabled channels with requests.
    logic [2:0]    win;             // Arbitration winner.
    logic          grant;           // A transfer starts this cycle.
    logic [15:0]   maddr_w;         // Memory address for the winner.
    logic          fin;             // Block completes this element.
    logic          halfhit;         // Half of block reached.
    logic [NCH-1:0] next_irq;       // Interrupt pulses for next cycle.

    // ------------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------------
    // Lowest set bit wins, so channel 0 has top priority.
    function automatic logic [2:0] first_one(input logic [NCH-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int k = NCH - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = k[2:0];
            end
        end
        return r;
    endfunction : first_one

    // True when the address selects channel register index x of channel c.
    function automatic logic hit(input logic [7:0] a, input int c, input logic [2:0] x);
        return (a[7:6] == 2'h0) && (a[5:3] == c[2:0]) && (a[2:0] == x);
    endfunction : hit

    // ------------------------------------------------------------------
    // Arbitration and block decode.
    // ------------------------------------------------------------------
    // Only enabled channels compete; a pending losing request just waits.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            ready[i] = pend[i] & ctrl[i][`ECD_B_EN];
        end
        win     = first_one(ready);
        grant   = (st == ecdma_pkg::ST_IDLE) && (|ready);
        // Peripheral indirect takes the address the peripheral offers.
        if (ctrl[win][5:4] == ecdma_pkg::AM_PERIND) begin
            maddr_w = per_ind_addr;
        end else begin
            maddr_w = cur_off[win];
        end
        fin     = (xcount[act] == count[act]);
        halfhit = (xcount[act] == (count[act] >> 1));
        next_irq = '0;
        if (st == ecdma_pkg::ST_WRITE) begin
            if (ctrl[act][`ECD_B_HALF] ? halfhit : fin) begin
                next_irq[act] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel registers and bookkeeping.
    // ------------------------------------------------------------------
    // Clears come before sets in this block, so in one cycle a set wins.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NCH; i++) begin
                ctrl[i]     <= 16'h0000;
                reqsel[i]   <= 16'h0000;
                prim_off[i] <= 16'h0000;
                sec_off[i]  <= 16'h0000;
                peraddr[i]  <= 16'h0000;
                count[i]    <= '0;
                cur_off[i]  <= 16'h0000;
                used_off[i] <= 16'h0000;
                xcount[i]   <= '0;
            end
            pp   <= '0;
            pend <= '0;
            mcol <= '0;
            pcol <= '0;
        end else begin
            // The grant clears first, so a pulse in the same cycle stays pending.
            if (grant) begin
                pend[win]     <= 1'b0;
                used_off[win] <= maddr_w;
            end
            // Selected source pulses raise a request on enabled channels.
            for (int i = 0; i < NCH; i++) begin
                if (ctrl[i][`ECD_B_EN] && irq_src[reqsel[i][6:0]]) begin
                    pend[i] <= 1'b1;
                end
            end
            if (st == ecdma_pkg::ST_WRITE) begin
                if (ctrl[act][5:4] == ecdma_pkg::AM_POSTINC) begin
                    cur_off[act] <= cur_off[act] +
                        (ctrl[act][`ECD_B_SIZE] ? `ECD_INC_BYTE : `ECD_INC_WORD);
                end
                reqsel[act][`ECD_B_FORCE] <= 1'b0;
                if (fin) begin
                    xcount[act] <= '0;
                    // Ping-pong flips the start register for the next block.
                    if (ctrl[act][1]) begin
                        pp[act]      <= ~pp[act];
                        cur_off[act] <= pp[act] ? prim_off[act] : sec_off[act];
                    end else begin
                        cur_off[act] <= prim_off[act];
                    end
                    if (ctrl[act][0]) begin
                        ctrl[act][`ECD_B_EN] <= 1'b0;
                    end
                end else begin
                    xcount[act] <= xcount[act] + 1'b1;
                end
            end
            // Register writes; setup writes while enabled are unsafe.
            for (int i = 0; i < NCH; i++) begin
                if (reg_wr && hit(reg_addr, i, `ECD_R_CTRL)) begin
                    ctrl[i] <= reg_wdata & `ECD_CTRL_MASK;
                    mcol[i] <= 1'b0;
                    pcol[i] <= 1'b0;
                    if (reg_wdata[`ECD_B_EN] && !ctrl[i][`ECD_B_EN]) begin
                        cur_off[i] <= prim_off[i];
                        xcount[i]  <= '0;
                        pp[i]      <= 1'b0;
                    end
                end
                if (reg_wr && hit(reg_addr, i, `ECD_R_REQ)) begin
                    reqsel[i][6:0] <= reg_wdata[6:0];
                    // Software can only set force, never clear it.
                    if (reg_wdata[`ECD_B_FORCE]) begin
                        reqsel[i][`ECD_B_FORCE] <= 1'b1;
                        pend[i] <= 1'b1;
                    end
                end
                if (reg_wr && hit(reg_addr, i, `ECD_R_PRIM)) begin
                    prim_off[i] <= reg_wdata;
                    used_off[i] <= reg_wdata;
                    cur_off[i]  <= reg_wdata;
                end
                if (reg_wr && hit(reg_addr, i, `ECD_R_SEC)) begin
                    sec_off[i]  <= reg_wdata;
                    used_off[i] <= reg_wdata;
                end
                if (reg_wr && hit(reg_addr, i, `ECD_R_PERADDR)) begin
                    peraddr[i] <= reg_wdata;
                end
                if (reg_wr && hit(reg_addr, i, `ECD_R_COUNT)) begin
                    count[i] <= reg_wdata[CW-1:0];
                end
            end
            // Collision sets come after the control write clear, so they win.
            if (st == ecdma_pkg::ST_WRITE && mem_wr && mem_collide) begin
                mcol[act] <= 1'b1;
            end
            if (st == ecdma_pkg::ST_WRITE && per_wr && per_collide) begin
                pcol[act] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transfer engine.
    // ------------------------------------------------------------------
    // One element takes four cycles: grant, read strobe, capture, write.
    // The memory port is private, so no processor stall is needed.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st            <= ecdma_pkg::ST_IDLE;
            act           <= 3'h0;
            mem_addr      <= 16'h0000;
            mem_wdata     <= 16'h0000;
            mem_rd        <= 1'b0;
            mem_wr        <= 1'b0;
            mem_byte      <= 1'b0;
            per_addr      <= 16'h0000;
            per_wdata     <= 16'h0000;
            per_rd        <= 1'b0;
            per_wr        <= 1'b0;
            per_byte      <= 1'b0;
            last_mem_addr <= 16'h0000;
            lastch        <= `ECD_LASTCH_RST;
        end else begin
            case (st)
                ecdma_pkg::ST_IDLE: begin
                    mem_wr <= 1'b0;
                    per_wr <= 1'b0;
                    if (grant) begin
                        act           <= win;
                        lastch        <= {1'b0, win};
                        mem_addr      <= maddr_w;
                        last_mem_addr <= maddr_w;
                        per_addr      <= peraddr[win];
                        mem_byte      <= ctrl[win][`ECD_B_SIZE];
                        per_byte      <= ctrl[win][`ECD_B_SIZE];
                        // Direction fixes which side is read.
                        mem_rd <= ctrl[win][`ECD_B_DIR];
                        per_rd <= ~ctrl[win][`ECD_B_DIR];
                        st     <= ecdma_pkg::ST_READ;
                    end
                end
                ecdma_pkg::ST_READ: begin
                    mem_rd <= 1'b0;
                    per_rd <= 1'b0;
                    st     <= ecdma_pkg::ST_CAPT;
                end
                ecdma_pkg::ST_CAPT: begin
                    if (ctrl[act][`ECD_B_DIR]) begin
                        per_wr    <= 1'b1;
                        per_wdata <= ctrl[act][`ECD_B_SIZE] ?
                                     {8'h00, mem_rdata[7:0]} : mem_rdata;
                    end else begin
                        mem_wr    <= 1'b1;
                        mem_wdata <= ctrl[act][`ECD_B_SIZE] ?
                                     {8'h00, per_rdata[7:0]} : per_rdata;
                        // Null write clears peripheral data alongside.
                        if (ctrl[act][`ECD_B_NULL_WRITE_SELECT]) begin
                            per_wr    <= 1'b1;
                            per_wdata <= 16'h0000;
                        end
                    end
                    st <= ecdma_pkg::ST_WRITE;
                end
                ecdma_pkg::ST_WRITE: begin
                    mem_wr <= 1'b0;
                    per_wr <= 1'b0;
                    st     <= ecdma_pkg::ST_IDLE;
                end
                default: begin
                    st <= ecdma_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pulses and register reads.
    // ------------------------------------------------------------------
    // Block interrupt is a registered one-cycle pulse.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            block_irq <= '0;
        end else begin
            block_irq <= next_irq;
        end
    end

    // Read data stands only in the cycle after the strobe; else zero.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                for (int i = 0; i < NCH; i++) begin
                    if (hit(reg_addr, i, `ECD_R_CTRL))    reg_rdata <= ctrl[i];
                    if (hit(reg_addr, i, `ECD_R_REQ))     reg_rdata <= reqsel[i];
                    if (hit(reg_addr, i, `ECD_R_PRIM))    reg_rdata <= used_off[i];
                    if (hit(reg_addr, i, `ECD_R_SEC))     reg_rdata <= used_off[i];
                    if (hit(reg_addr, i, `ECD_R_PERADDR)) reg_rdata <= peraddr[i];
                    if (hit(reg_addr, i, `ECD_R_COUNT)) begin
                        reg_rdata <= 16'(count[i]) & `ECD_COUNT_MASK;
                    end
                end
                if (reg_addr == `ECD_G_LASTADDR) reg_rdata <= last_mem_addr;
                if (reg_addr == `ECD_G_COLL)     reg_rdata <= {pcol, mcol};
                if (reg_addr == `ECD_G_LASTCH)   reg_rdata <= {4'h0, lastch, pp};
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    sequence s_read;
        (mem_rd || per_rd);
    endsequence
    sequence s_write;
        ##2 (mem_wr || per_wr);
    endsequence
    chk_grant_lowest: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grant |-> ((ready & ((8'h01 << win) - 8'h01)) == 8'h00) ##1 (act == $past(win)))
        else $error("grant did not go to lowest ready channel");
    chk_read_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_read |-> s_write)
        else $error("read not followed by write two cycles later");
    chk_one_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mem_rd |-> ##2 (per_wr && !mem_wr))
        else $error("memory read not paired with peripheral write");
    chk_null_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mem_wr && ctrl[act][`ECD_B_NULL_WRITE_SELECT]) |-> (per_wr && per_wdata == 16'h0000))
        else $error("null write missing");
    chk_byte_lane: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mem_wr && mem_byte) |-> (mem_wdata[15:8] == 8'h00))
        else $error("byte transfer carried upper byte");
    chk_force_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st == ecdma_pkg::ST_WRITE && !reg_wr) |=> !reqsel[act][`ECD_B_FORCE])
        else $error("force bit not cleared after transfer");
    chk_last_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mem_rd || mem_wr) |-> (last_mem_addr == mem_addr))
        else $error("last memory address not captured");
    chk_oneshot_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st == ecdma_pkg::ST_WRITE && fin && ctrl[act][0] && !reg_wr)
        |=> !ctrl[act][`ECD_B_EN])
        else $error("one-shot channel still enabled");
    chk_full_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st == ecdma_pkg::ST_WRITE && fin && !ctrl[act][`ECD_B_HALF]) |=> block_irq[act])
        else $error("block interrupt missing at completion");
endmodule : ecdma_top

// ---- sim/ecdma_far_model.sv ----
// Behavioural model of the peripheral bus and the memory second port.
`timescale 1ns/10ps
module ecdma_far_model (
    // Clock.
    input  wire logic        clk_sys,
    // Memory second port.
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    output logic      [15:0] mem_rdata,
    // Peripheral bus.
    input  wire logic [15:0] per_addr,
    input  wire logic        per_rd,
    output logic      [15:0] per_rdata
);
    // Both start from a known value, so the bench never sees unknowns.
    initial begin
        mem_rdata = 16'h0000;
        per_rdata = 16'h0000;
    end

    // Read data stand only in the cycle after the strobe. Otherwise the data
    // toggle each cycle, so that a sample one cycle late can never match by luck.
    // The memory side answers on its own port, apart from any processor.
    always @(posedge clk_sys) begin
        mem_rdata <= mem_rd ? (mem_addr ^ 16'hc3c3) : ~mem_rdata;
        per_rdata <= per_rd ? (per_addr ^ 16'h5a5a) : ~per_rdata;
    end
endmodule : ecdma_far_model

// ---- sim/tb_ecdma_top.sv ----
// Self-checking bench for the eight-channel transfer controller.
`timescale 1ns/10ps
module tb_ecdma_top;
    // -------------------------------------------------------------------
    // Signals.
    // -------------------------------------------------------------------
    logic         clk_sys   = 1'b0;     // System clock, 100 ns period.
    logic         rst_n     = 1'b0;     // Reset, active low.
    logic [7:0]   reg_addr  = 8'h00;    // Register word index.
    logic [15:0]  reg_wdata = 16'h0000; // Register write data.
    logic         reg_wr    = 1'b0;     // Write strobe.
    logic         reg_rd    = 1'b0;     // Read strobe.
    logic [127:0] irq_src   = '0;       // Trigger sources.
    logic         mem_collide  = 1'b0;     // Memory write collision input.
    logic         per_collide  = 1'b0;     // Peripheral write collision input.
    logic [15:0]  per_ind_addr = 16'h0000; // Memory offset offered by the peripheral.
    logic [15:0]  reg_rdata, mem_addr, mem_wdata, mem_rdata;
    logic [15:0]  per_addr, per_wdata, per_rdata;
    logic         mem_rd, mem_wr, mem_byte, per_rd, per_wr, per_byte;
    logic [7:0]   block_irq;
    logic [15:0]  mw_a[$];              // Memory write addresses seen.
    logic [15:0]  mw_d[$];              // Memory write data seen.
    logic [15:0]  pw_d[$];              // Peripheral write data seen.
    int           fails      = 0;
    int           num_checks = 0;

    always #50 clk_sys = ~clk_sys;

    // Collision inputs and the indirect address are driven by the main sequence.
    ecdma_top dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_src(irq_src),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_byte(mem_byte), .mem_rdata(mem_rdata), .mem_collide(mem_collide),
        .per_addr(per_addr), .per_wdata(per_wdata), .per_rd(per_rd), .per_wr(per_wr),
        .per_byte(per_byte), .per_rdata(per_rdata), .per_ind_addr(per_ind_addr),
        .per_collide(per_collide), .block_irq(block_irq));

    ecdma_far_model far (
        .clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
        .per_addr(per_addr), .per_rd(per_rd), .per_rdata(per_rdata));

    // Log every write strobe, since each stands for one cycle only.
    always @(posedge clk_sys) begin
        if (mem_wr === 1'b1) begin
            mw_a.push_back(mem_addr);
            mw_d.push_back(mem_wdata);
        end
        if (per_wr === 1'b1) begin
            pw_d.push_back(per_wdata);
        end
    end

    // -------------------------------------------------------------------
    // Tasks.
    // -------------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask : rd

    // A hang here ends the run rather than stalling it.
    task automatic wait_irq(input int ch);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            #1;
            if (block_irq[ch] === 1'b1) return;
        end
        fails++;
        wrap_up();
    endtask : wait_irq

    // -------------------------------------------------------------------
    // Main sequence.
    // -------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h40, 16'h0000);
        rd(8'h42, 16'h0f00);
        rd(8'h00, 16'h0000);
        wr(8'h38, 16'hffff);
        rd(8'h38, 16'hf833);
        wr(8'h38, 16'h0000);
        wr(8'h0d, 16'hffff);
        rd(8'h0d, 16'h03ff);
        wr(8'h0c, 16'ha5c3);
        rd(8'h0c, 16'ha5c3);
        rd(8'h7f, 16'h0000);
        $display("test registers done");
        // Set up fully before enabling, then force one word in.
        wr(8'h04, 16'h1230);
        wr(8'h02, 16'h0100);
        wr(8'h05, 16'h0000);
        wr(8'h00, 16'h8001);
        wr(8'h01, 16'h8000);
        wait_irq(0);
        check(mw_a[0], 16'h0100);
        check(mw_d[0], 16'h1230 ^ 16'h5a5a);
        rd(8'h01, 16'h0000);
        rd(8'h40, 16'h0100);
        rd(8'h02, 16'h0100);
        rd(8'h42, 16'h0000);
        $display("test forced transfer done");
        // Channels 1 and 2 share source 5 and fire together.
        wr(8'h0c, 16'h2000);
        wr(8'h0a, 16'h0300);
        wr(8'h0d, 16'h0000);
        wr(8'h09, 16'h0005);
        wr(8'h08, 16'h8001);
        wr(8'h14, 16'h2002);
        wr(8'h12, 16'h0400);
        wr(8'h15, 16'h0000);
        wr(8'h11, 16'h0005);
        wr(8'h10, 16'h8001);
        @(posedge clk_sys);
        irq_src[5] <= 1'b1;
        @(posedge clk_sys);
        irq_src[5] <= 1'b0;
        wait_irq(2);
        check(mw_a[1], 16'h0300);
        check(mw_a[2], 16'h0400);
        rd(8'h42, 16'h0200);
        $display("test priority done");
        // Two bytes from memory to the peripheral; the count is elements.
        wr(8'h24, 16'h3000);
        wr(8'h22, 16'h0200);
        wr(8'h25, 16'h0001);
        wr(8'h20, 16'he000);
        wr(8'h21, 16'h8000);
        repeat (6) @(posedge clk_sys);
        wr(8'h21, 16'h8000);
        wait_irq(4);
        check(16'(pw_d.size()), 16'h0002);
        check(pw_d[0], 16'h00c3);
        check(pw_d[1], 16'h00c2);
        check({14'h0000, mem_byte, per_byte}, 16'h0003);
        $display("test byte block done");
        // Channel 3 ping-pongs with null writes while both collision inputs stand high.
        @(posedge clk_sys);
        mem_collide <= 1'b1;
        per_collide <= 1'b1;
        wr(8'h1c, 16'h4000);
        wr(8'h1a, 16'h0500);
        wr(8'h1b, 16'h0600);
        wr(8'h1d, 16'h0000);
        wr(8'h18, 16'h8802);
        wr(8'h19, 16'h8000);
        wait_irq(3);
        check(mw_a[3], 16'h0500);
        check(pw_d[2], 16'h0000);
        check(per_addr, 16'h4000);
        rd(8'h41, 16'h0808);
        rd(8'h42, 16'h0308);
        wr(8'h19, 16'h8000);
        wait_irq(3);
        check(mw_a[4], 16'h0600);
        rd(8'h1b, 16'h0600);
        rd(8'h18, 16'h8802);
        $display("test ping-pong done");
        // Channel 5 takes its memory offset from the peripheral, once.
        @(posedge clk_sys);
        per_ind_addr <= 16'h0700;
        wr(8'h2c, 16'h5000);
        wr(8'h28, 16'h8021);
        wr(8'h29, 16'h8000);
        wait_irq(5);
        check(mw_a[5], 16'h0700);
        rd(8'h28, 16'h0021);
        $display("test indirect done");
        wrap_up();
    end
endmodule : tb_ecdma_top
